// *** agc_pkg.sv ***
// Package: register map, field layout and timing constants of the gain and chop configuration block
package agc_pkg;

   // ****************************************
   // Register indices and byte addresses
   // ****************************************
   localparam logic [7:0]  IDX_GAIN     = 8'h04;
   localparam logic [7:0]  IDX_RSVD     = 8'h05;
   localparam logic [7:0]  IDX_CHOP     = 8'h06;
   localparam logic [9:0]  ADDR_GAIN    = {IDX_GAIN, 2'b00};
   localparam logic [9:0]  ADDR_RSVD    = {IDX_RSVD, 2'b00};
   localparam logic [9:0]  ADDR_CHOP    = {IDX_CHOP, 2'b00};
   // Own addition: live status of the chop sequencer
   localparam logic [9:0]  ADDR_STAT    = 10'h020;

   // ****************************************
   // Reset values and field positions
   // ****************************************
   localparam logic [15:0] GAIN_RST     = 16'h0000;
   localparam logic [15:0] RSVD_RST     = 16'h0000;
   localparam logic [15:0] CHOP_RST     = 16'h0600;
   localparam int          CH0_LSB      = 0;
   localparam int          CH1_LSB      = 4;
   localparam int          CH2_LSB      = 8;
   localparam int          CH3_LSB      = 12;
   localparam int          CHOP_EN_BIT  = 8;
   localparam int          DLY_LSB      = 9;

   // Modulator clock enable every MOD_DIV core cycles
   localparam int          MOD_DIV      = 4;
   // Measurement length of each chop phase in modulator periods, settle time not included
   localparam int          PHASE_LEN    = 64;

   typedef struct packed {
      logic [2:0] ch3_gain_code;
      logic [2:0] ch2_gain_code;
      logic [2:0] ch1_gain_code;
      logic [2:0] ch0_gain_code;
   } agc_gain_t;

   typedef struct packed {
      logic       chop_enable;
      logic [3:0] chop_settle_delay;
   } agc_chop_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETTLE,
      ST_MEASURE
   } agc_state_t;

endpackage : agc_pkg

// *** agc_gain_dec.sv ***
// Module: 3-bit gain code to power-of-two amplifier gain
`timescale 1ns/1ps
module agc_gain_dec
   import agc_pkg::*;
(
   input  wire logic [2:0] code_i,
   output logic      [7:0] gain_o
);
   // Code n selects gain two to the n
   assign gain_o = 8'h01 << code_i;
endmodule : agc_gain_dec

// *** agc_top.sv ***
// Module: gain selection and global chop configuration registers with chop settle sequencer
//
// Operation
// R01 - Gain register at 04h resets to zero, unity gain on every channel
// R02 - Bits 14:12 hold channel 3 code, gain two to code
// R03 - Bits 10:8 hold channel 2 code, same power-of-two encoding
// R04 - Bits 6:4 hold channel 1 code, same power-of-two encoding
// R05 - Bits 2:0 hold channel 0 code, same power-of-two encoding
// R06 - Host writes zero to gain bits 15, 11, 7, 3; stored anyway
// R07 - Register 05h reserved, resets zero, host writes zeros only
// R08 - Chop register at 06h resets 0600h, chop off, delay code 3
// R09 - With chop enabled, wait two to code-plus-one modulator periods before measuring
// R10 - Delay counted in modulator periods; new code used at next phase change
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module agc_top
   import agc_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [9:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output agc_gain_t        gain_codes_o,
   output logic      [31:0] gains_o,
   output logic             chop_phase_o,
   output logic             measure_o
);

   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] gain_ff;
   logic [15:0] rsvd_ff;
   logic [15:0] chop_ff;
   logic [31:0] rdata_ff;
   logic        err_ff;
   logic        wr_en;
   logic        rd_en;
   logic        hit;
   logic [15:0] wmask;
   logic [15:0] nxt_rdata;

   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && !penable_i && !pwrite_i;
   assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   assign hit   = (paddr_i == ADDR_GAIN) || (paddr_i == ADDR_RSVD) ||
                  (paddr_i == ADDR_CHOP) || (paddr_i == ADDR_STAT);

   // Zero wait states: every access completes in its first access cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = err_ff && psel_i && penable_i;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         gain_ff <= GAIN_RST; // R01
      end else if (wr_en && paddr_i == ADDR_GAIN) begin
         // Reserved bits are stored as written, host keeps them zero
         gain_ff <= (gain_ff & ~wmask) | (pwdata_i[15:0] & wmask); // R02 R03 R04 R05 R06
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rsvd_ff <= RSVD_RST; // R07
      end else if (wr_en && paddr_i == ADDR_RSVD) begin
         rsvd_ff <= (rsvd_ff & ~wmask) | (pwdata_i[15:0] & wmask); // R07
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         chop_ff <= CHOP_RST; // R08
      end else if (wr_en && paddr_i == ADDR_CHOP) begin
         chop_ff <= (chop_ff & ~wmask) | (pwdata_i[15:0] & wmask); // R08
      end
   end

   // ****************************************
   // Read path, captured in setup phase
   // ****************************************
   agc_state_t  state_ff;
   logic        phase_ff;

   always_comb begin
      nxt_rdata = 16'h0000;
      case (paddr_i)
         ADDR_GAIN: nxt_rdata = gain_ff;
         ADDR_RSVD: nxt_rdata = rsvd_ff;
         ADDR_CHOP: nxt_rdata = chop_ff;
         ADDR_STAT: nxt_rdata = {13'h0000, phase_ff, state_ff};
         default:   nxt_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_ff <= {16'h0000, nxt_rdata};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         err_ff <= 1'b0;
      end else if (psel_i && !penable_i) begin
         // Unmapped address answers with an error; writes to status too
         err_ff <= !hit || (pwrite_i && paddr_i == ADDR_STAT);
      end
   end

   assign prdata_o = rdata_ff;

   // ****************************************
   // Gain outputs
   // ****************************************
   assign gain_codes_o.ch3_gain_code = gain_ff[CH3_LSB +: 3]; // R02
   assign gain_codes_o.ch2_gain_code = gain_ff[CH2_LSB +: 3]; // R03
   assign gain_codes_o.ch1_gain_code = gain_ff[CH1_LSB +: 3]; // R04
   assign gain_codes_o.ch0_gain_code = gain_ff[CH0_LSB +: 3]; // R05

   agc_gain_dec u_dec0 (.code_i(gain_codes_o.ch0_gain_code), .gain_o(gains_o[7:0]));   // R05
   agc_gain_dec u_dec1 (.code_i(gain_codes_o.ch1_gain_code), .gain_o(gains_o[15:8]));  // R04
   agc_gain_dec u_dec2 (.code_i(gain_codes_o.ch2_gain_code), .gain_o(gains_o[23:16])); // R03
   agc_gain_dec u_dec3 (.code_i(gain_codes_o.ch3_gain_code), .gain_o(gains_o[31:24])); // R02

   // ****************************************
   // Modulator clock enable
   // ****************************************
   logic [7:0] div_ff;
   logic       mod_tick;

   assign mod_tick = (div_ff == 8'(MOD_DIV - 1));

   always_ff @(posedge core_clk_i) begin
      if (reset_i || mod_tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // ****************************************
   // Chop sequencer
   // ****************************************
   agc_chop_t   cfg;
   logic [16:0] cnt_ff;
   logic [16:0] settle_len;
   logic [3:0]  dly_ff;

   assign cfg.chop_enable       = chop_ff[CHOP_EN_BIT];
   assign cfg.chop_settle_delay = chop_ff[DLY_LSB +: 4];
   // Code n waits two to n plus one periods; 1101b taken as 16384
   assign settle_len = 17'h0_0002 << dly_ff; // R09

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 17'h0_0000;
         phase_ff <= 1'b0;
         dly_ff   <= CHOP_RST[DLY_LSB +: 4];
      end else if (!cfg.chop_enable) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 17'h0_0000;
         phase_ff <= 1'b0;
      end else if (mod_tick) begin // R10
         case (state_ff)
            ST_IDLE: begin
               // Delay code latched on leaving idle, and again at each phase change
               dly_ff   <= cfg.chop_settle_delay; // R10
               cnt_ff   <= 17'h0_0000;
               state_ff <= ST_SETTLE;
            end
            ST_SETTLE: begin
               if (cnt_ff == settle_len - 17'h0_0001) begin // R09
                  cnt_ff   <= 17'h0_0000;
                  state_ff <= ST_MEASURE;
               end else begin
                  cnt_ff <= cnt_ff + 17'h0_0001;
               end
            end
            ST_MEASURE: begin
               if (cnt_ff == 17'(PHASE_LEN - 1)) begin
                  cnt_ff   <= 17'h0_0000;
                  phase_ff <= !phase_ff;
                  dly_ff   <= cfg.chop_settle_delay; // R10
                  state_ff <= ST_SETTLE;
               end else begin
                  cnt_ff <= cnt_ff + 17'h0_0001;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   assign chop_phase_o = phase_ff;
   // Without chopping, measurement runs continuously
   assign measure_o    = !cfg.chop_enable || (state_ff == ST_MEASURE); // R09

endmodule : agc_top

// *** agc_monitor.sv ***
// Checker of the gain and chop configuration block
`timescale 1ns/1ps
module agc_monitor
   import agc_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [9:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire agc_gain_t   gain_codes_o,
   input wire logic [31:0] gains_o,
   input wire logic        chop_phase_o,
   input wire logic        measure_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   logic wg;
   assign wg = psel_i && penable_i && pwrite_i && paddr_i == ADDR_GAIN;
   property p_rst; $fell(reset_i) |-> gain_codes_o == 12'h000 && measure_o && !chop_phase_o; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_c3; wg && pstrb_i[1] |=> gain_codes_o.ch3_gain_code == $past(pwdata_i[14:12]); endproperty
   a_c3: assert property (p_c3) else $error("ch3 code not stored");
   property p_c2; wg && pstrb_i[1] |=> gain_codes_o.ch2_gain_code == $past(pwdata_i[10:8]); endproperty
   a_c2: assert property (p_c2) else $error("ch2 code not stored");
   property p_c1; wg && pstrb_i[0] |=> gain_codes_o.ch1_gain_code == $past(pwdata_i[6:4]); endproperty
   a_c1: assert property (p_c1) else $error("ch1 code not stored");
   property p_c0; wg && pstrb_i[0] |=> gain_codes_o.ch0_gain_code == $past(pwdata_i[2:0]); endproperty
   a_c0: assert property (p_c0) else $error("ch0 code not stored");
   property p_dec; gains_o == {8'h01 << gain_codes_o.ch3_gain_code, 8'h01 << gain_codes_o.ch2_gain_code,
      8'h01 << gain_codes_o.ch1_gain_code, 8'h01 << gain_codes_o.ch0_gain_code}; endproperty
   a_dec: assert property (p_dec) else $error("gain decode wrong");
   property p_set; $fell(measure_o) |-> !measure_o [*8]; endproperty
   a_set: assert property (p_set) else $error("settle shorter than two periods");
   property p_ph; $changed(chop_phase_o) |-> $fell(measure_o); endproperty
   a_ph: assert property (p_ph) else $error("phase change without settle");
endmodule : agc_monitor
bind agc_top agc_monitor i_mon (.*);

// *** agc_host.sv ***
// Host model issuing APB transfers to the configuration block
`timescale 1ns/1ps
module agc_host
(
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [9:0]  paddr_o,
   output logic      [31:0] pwdata_o,
   output logic      [3:0]  pstrb_o
);
   initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
   // Released bus shows inverted address and data so stale data is never mistaken for valid
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {psel_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} <= {1'b1, w, a, d, 4'hf};
      @(posedge clk_i);
      penable_o <= 1'b1;
      // Waits for as long as the slave stalls; only the bench watchdog ends a hang
      do @(posedge clk_i); while (!pready_i);
      {psel_o, penable_o, paddr_o, pwdata_o} <= {2'b00, ~a, ~d};
   endtask : xfer
endmodule : agc_host

// *** testbench.sv ***
// Self-checking bench of the gain and chop configuration block
`timescale 1ns/1ps
module testbench import agc_pkg::*;;
   logic        clk, rst, psel, pen, pwr, prdy, perr, phase, meas;
   logic [9:0]  addr;
   logic [3:0]  strb;
   logic [31:0] wdata, rdata, gains, d;
   agc_gain_t   codes;
   logic [32:0] q[$], e;
   logic [3:0]  cl[3] = '{4'h2, 4'h0, 4'h5};
   int          n_fail = 0, compares = 0, n;
   agc_top i_agc_top (.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(addr), .pwdata_i(wdata), .pstrb_i(strb), .prdata_o(rdata), .pready_o(prdy), .pslverr_o(perr),
      .gain_codes_o(codes), .gains_o(gains), .chop_phase_o(phase), .measure_o(meas));
   agc_host i_agc_host (.clk_i(clk), .pready_i(prdy), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
      .paddr_o(addr), .pwdata_o(wdata), .pstrb_o(strb));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_err(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk_err
   task automatic chk_gain(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask : chk_gain
   task automatic chk_cnt(input int got, input int exp);
      chk(got, exp);
   endtask : chk_cnt
   task automatic results;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   // Expected error flag and read data are noted before each transfer
   task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] x, input logic err);
      q.push_back({err, x});
      i_agc_host.xfer(w, a, w ? x : ~x);
   endtask : acc
   always @(posedge clk) if (psel && pen && prdy) begin
      e = q.pop_front();
      chk_err(perr, e[32]);
      if (!pwr && !e[32]) chk(rdata, e[31:0]);
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      results();
   end
   initial begin
      rst = 1'b1;
      void'($urandom(32'h0000_ebbf));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      acc(0, ADDR_GAIN, 32'h0000_0000, 0);
      acc(0, ADDR_RSVD, 32'h0000_0000, 0);
      acc(0, ADDR_CHOP, 32'h0000_0600, 0);
      for (int i = 0; i < 8; i++) begin
         d = ($urandom & 32'h0000_7770) | i;
         acc(1, ADDR_GAIN, d, 0);
         acc(0, ADDR_GAIN, d, 0);
         @(negedge clk);
         chk_gain(gains, {8'h01 << d[14:12], 8'h01 << d[10:8], 8'h01 << d[6:4], 8'h01 << d[2:0]});
      end
      acc(1, 10'h0fc, 32'h0000_0777, 1);
      acc(1, ADDR_STAT, 32'h0000_0000, 1);
      acc(0, ADDR_GAIN, d, 0);
      acc(1, ADDR_RSVD, 32'h0000_0000, 0);
      acc(1, ADDR_CHOP, 32'h0000_0100, 0);
      foreach (cl[k]) begin
         @(posedge meas);
         acc(1, ADDR_CHOP, {19'h0, cl[k], 9'h100}, 0);
         @(negedge meas);
         // Count only the core cycles in which measurement is held off
         n = 0;
         @(negedge clk);
         while (!meas) begin
            n++;
            @(negedge clk);
         end
         chk_cnt(n, (2 << cl[k]) * MOD_DIV);
      end
      results();
   end
endmodule : testbench
